// ==== verilog/mlsi_pkg.sv ====
// Shared constants, types and decoding helpers for the multi-lane serial flash pin block
package mlsi_pkg;

  localparam int ADDR_BITS = 24;
  localparam logic [4:0] INSTR_LAST = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;

  // Command codes (single, dual, quad, double rate, program, erase)
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_DREAD = 8'h3b;
  localparam logic [7:0] OP_QREAD = 8'h6b;
  localparam logic [7:0] OP_DDR_READ = 8'h0d;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_ERASE = 8'hd8;

  // Erase unit sizes as address bit counts: 4 kbytes, 64 kbytes, 256 kbytes
  localparam logic [4:0] SECT_4K_BITS = 5'h0c;
  localparam logic [4:0] SECT_64K_BITS = 5'h10;
  localparam logic [4:0] SECT_256K_BITS = 5'h12;
  // Hybrid layout: thirty-two small sectors at the bottom of the address space
  localparam logic [23:0] HYB_SMALL_LIMIT = 24'h020000;

  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [2:0] W1 = 3'h1;
  localparam logic [2:0] W2 = 3'h2;
  localparam logic [2:0] W4 = 3'h4;

  // Synchroniser reset image: {quad, lane3..lane0, cs_n, sck}
  localparam logic [6:0] SYNC_RST = 7'h3e;

  typedef enum logic [2:0] {ST_INSTR, ST_ADDR, ST_DIN, ST_OUT, ST_IGNORE} mlsi_state_t;
  typedef enum logic [1:0] {K_READ, K_PROG, K_ERASE} mlsi_kind_t;

  function automatic logic [4:0] mlsi_sector_bits(input logic uniform, input logic [23:0] addr);
    if (uniform) begin
      return SECT_256K_BITS;
    end else if (addr < HYB_SMALL_LIMIT) begin
      return SECT_4K_BITS;
    end else begin
      return SECT_64K_BITS;
    end
  endfunction

endpackage

// ==== verilog/mlsi_array.sv ====
// Flip-flop storage array with single-step byte rewrite and sector erase
`timescale 1ns/10ps
module mlsi_array import mlsi_pkg::*; #(
  parameter int DEPTH = 64,
  parameter bit UNIFORM = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [23:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic erase_en,
  input wire logic [23:0] erase_addr,
  input wire logic [23:0] rd_addr,
  output logic [7:0] rd_data
);

  localparam int IW = $clog2(DEPTH);

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] mem_next [DEPTH];
  logic [23:0] sect_mask;
  logic [23:0] erase_wrap;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || IW > ADDR_BITS) begin : g_bad_depth
    $error("mlsi_array: DEPTH must be a power of two between 2 and 2**24");
  end

  // Addresses wrap on the array size; the sector size still follows the full address
  assign sect_mask = ~((24'h000001 << mlsi_sector_bits(UNIFORM, erase_addr)) - 24'h000001);
  assign erase_wrap = 24'(erase_addr[IW-1:0]);
  assign rd_data = mem_reg[rd_addr[IW-1:0]];

  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    always_comb begin
      mem_next[i] = mem_reg[i];
      if (erase_en && ((24'(i) & sect_mask) == (erase_wrap & sect_mask))) begin
        mem_next[i] = ERASED_BYTE;
      end else if (wr_en && wr_addr[IW-1:0] == IW'(i)) begin
        // Erase and reprogram of the byte appear as one rewrite to the host
        mem_next[i] = wr_data;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        mem_reg[i] <= ERASED_BYTE;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  prog_store_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr_en && !erase_en) |=> mem_reg[$past(wr_addr[IW-1:0])] == $past(wr_data))
    else $error("written byte not stored in one step");

endmodule // mlsi_array

// ==== verilog/mlsi_flash_pins.sv ====
// Device-side pin logic of a multi-lane serial flash, oversampling the serial clock
// Summary of operation
// - Inputs taken on serial clock rise; single-rate output changes on its fall.
// - Erase unit is 4, 64 or 256 kbytes by variant and address.
// - A write rewrites the byte in one step, no separate erase needed.
// - Low hardware reset returns the device to standby, ready for a command.
// - Lane zero is serial input for single commands, data lane zero otherwise.
// - Lane one is serial output for single commands, data lane one otherwise.
// - Lane two is write-protect input unless quad mode, then data lane two.
// - Besides one-bit, commands move two or four bits per clock.
// - Double-rate commands transfer on both serial clock edges.
// - Every command opens with an eight-bit instruction from the host.
// - Chip select high: inputs ignored, all outputs released.
// - Lane three pauses any command unless quad mode, then data lane three.
`timescale 1ns/10ps
module mlsi_flash_pins import mlsi_pkg::*; #(
  parameter int MEM_DEPTH = 64,
  parameter bit UNIFORM_SECTORS = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic quad_mode_en,
  input wire logic lane0_serial_in_in,
  output logic lane0_serial_in_out,
  output logic lane0_serial_in_oe,
  input wire logic lane1_serial_out_in,
  output logic lane1_serial_out_out,
  output logic lane1_serial_out_oe,
  input wire logic lane2_write_protect_n_in,
  output logic lane2_write_protect_n_out,
  output logic lane2_write_protect_n_oe,
  input wire logic lane3_pause_n_in,
  output logic lane3_pause_n_out,
  output logic lane3_pause_n_oe
);

  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic sck_prev_reg;
  logic sck_s, cs_s, quad_s;
  logic [3:0] lane_s;
  logic sck_rise, sck_fall, paused, act_rise, act_fall, wp_ok;

  mlsi_state_t state_reg, state_next;
  mlsi_kind_t kind_reg, kind_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [7:0] instr_reg, instr_next;
  logic [23:0] addr_reg, addr_next;
  logic [2:0] width_reg, width_next;
  logic ddr_reg, ddr_next;
  logic [7:0] byte_reg, byte_next;
  logic [2:0] out_cnt_reg, out_cnt_next;
  logic [3:0] lane_out_reg, lane_out_next;
  logic [3:0] lane_oe_reg, lane_oe_next;

  logic [7:0] opcode;
  logic [23:0] addr_shift;
  logic [7:0] out_byte, din_byte, rd_data;
  logic wr_en, erase_en;

  // Pins are asynchronous to clk; the serial clock is just another sampled input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      sck_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {quad_mode_en, lane3_pause_n_in, lane2_write_protect_n_in,
                    lane1_serial_out_in, lane0_serial_in_in, cs_n, sck};
      sync2_reg <= sync1_reg;
      sck_prev_reg <= sync2_reg[0];
    end
  end

  assign sck_s = sync2_reg[0];
  assign cs_s = sync2_reg[1];
  assign lane_s = sync2_reg[5:2];
  assign quad_s = sync2_reg[6];
  assign sck_rise = sck_s && !sck_prev_reg;
  assign sck_fall = !sck_s && sck_prev_reg;
  assign paused = !quad_s && !lane_s[3];
  assign act_rise = sck_rise && !paused && !cs_s;
  assign act_fall = sck_fall && !paused && !cs_s;
  assign wp_ok = quad_s || lane_s[2];
  assign opcode = {instr_reg[6:0], lane_s[0]};
  assign addr_shift = {addr_reg[22:0], lane_s[0]};

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    instr_next = instr_reg;
    addr_next = addr_reg;
    width_next = width_reg;
    ddr_next = ddr_reg;
    byte_next = byte_reg;
    out_cnt_next = out_cnt_reg;
    lane_out_next = lane_out_reg;
    lane_oe_next = lane_oe_reg;
    out_byte = 8'h00;
    din_byte = 8'h00;
    wr_en = 1'b0;
    erase_en = 1'b0;
    if (cs_s) begin
      // Deselected: drop the command and release every lane
      state_next = ST_INSTR;
      cnt_next = 5'h00;
      out_cnt_next = 3'h0;
      lane_oe_next = 4'h0;
    end else begin
      unique case (state_reg)
        ST_INSTR: begin
          if (act_rise) begin
            instr_next = opcode;
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == INSTR_LAST) begin
              cnt_next = 5'h00;
              state_next = ST_ADDR;
              width_next = W1;
              ddr_next = 1'b0;
              kind_next = K_READ;
              unique case (opcode)
                OP_READ: kind_next = K_READ;
                OP_DREAD: width_next = W2;
                OP_QREAD: begin
                  width_next = W4;
                  if (!quad_s) begin
                    state_next = ST_IGNORE;
                  end
                end
                OP_DDR_READ: ddr_next = 1'b1;
                OP_PROG: kind_next = K_PROG;
                OP_QPROG: begin
                  kind_next = K_PROG;
                  width_next = W4;
                  if (!quad_s) begin
                    state_next = ST_IGNORE;
                  end
                end
                OP_ERASE: kind_next = K_ERASE;
                default: state_next = ST_IGNORE;
              endcase
            end
          end
        end
        ST_ADDR: begin
          // Double-rate address starts on a rise: the fall that trails the instruction is not a bit
          if (act_rise || (ddr_reg && act_fall && cnt_reg != 5'h00)) begin
            addr_next = addr_shift;
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == ADDR_LAST) begin
              cnt_next = 5'h00;
              out_cnt_next = 3'h0;
              unique case (kind_reg)
                K_READ: state_next = ST_OUT;
                K_PROG: state_next = ST_DIN;
                K_ERASE: begin
                  erase_en = wp_ok;
                  state_next = ST_IGNORE;
                end
              endcase
            end
          end
        end
        ST_OUT: begin
          if (act_fall || (ddr_reg && act_rise)) begin
            out_byte = (out_cnt_reg == 3'h0) ? rd_data : byte_reg;
            unique case (width_reg)
              W2: begin
                lane_out_next[1:0] = out_byte[7:6];
                lane_oe_next = 4'h3;
              end
              W4: begin
                lane_out_next = out_byte[7:4];
                lane_oe_next = 4'hf;
              end
              default: begin
                lane_out_next[1] = out_byte[7];
                lane_oe_next = 4'h2;
              end
            endcase
            byte_next = out_byte << width_reg;
            out_cnt_next = out_cnt_reg + width_reg;
            if (out_cnt_next == 3'h0) begin
              addr_next = addr_reg + 24'h000001;
            end
          end
        end
        ST_DIN: begin
          if (act_rise) begin
            din_byte = (width_reg == W4) ? {byte_reg[3:0], lane_s} : {byte_reg[6:0], lane_s[0]};
            byte_next = din_byte;
            out_cnt_next = out_cnt_reg + width_reg;
            if (out_cnt_next == 3'h0) begin
              wr_en = wp_ok;
              addr_next = addr_reg + 24'h000001;
            end
          end
        end
        ST_IGNORE: begin
          state_next = ST_IGNORE;
        end
      endcase
    end
  end

  // The hardware reset pin is resetn: it aborts everything and returns to standby
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_INSTR;
      kind_reg <= K_READ;
      cnt_reg <= 5'h00;
      instr_reg <= 8'h00;
      addr_reg <= 24'h000000;
      width_reg <= W1;
      ddr_reg <= 1'b0;
      byte_reg <= 8'h00;
      out_cnt_reg <= 3'h0;
      lane_out_reg <= 4'h0;
      lane_oe_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      instr_reg <= instr_next;
      addr_reg <= addr_next;
      width_reg <= width_next;
      ddr_reg <= ddr_next;
      byte_reg <= byte_next;
      out_cnt_reg <= out_cnt_next;
      lane_out_reg <= lane_out_next;
      lane_oe_reg <= lane_oe_next;
    end
  end

  mlsi_array #(
    .DEPTH(MEM_DEPTH),
    .UNIFORM(UNIFORM_SECTORS)
  ) u_array (
    .clk(clk),
    .resetn(resetn),
    .wr_en(wr_en),
    .wr_addr(addr_reg),
    .wr_data(din_byte),
    .erase_en(erase_en),
    .erase_addr(addr_shift),
    .rd_addr(addr_reg),
    .rd_data(rd_data)
  );

  assign lane0_serial_in_out = lane_out_reg[0];
  assign lane1_serial_out_out = lane_out_reg[1];
  assign lane2_write_protect_n_out = lane_out_reg[2];
  assign lane3_pause_n_out = lane_out_reg[3];
  assign lane0_serial_in_oe = lane_oe_reg[0];
  assign lane1_serial_out_oe = lane_oe_reg[1];
  assign lane2_write_protect_n_oe = lane_oe_reg[2];
  assign lane3_pause_n_oe = lane_oe_reg[3];

  cs_high_release_a: assert property (@(posedge clk) disable iff (!resetn)
    cs_s |=> lane_oe_reg == 4'h0)
    else $error("lanes driven while deselected");

  sdr_fall_change_a: assert property (@(posedge clk) disable iff (!resetn)
    (!$past(ddr_reg) && $changed(lane_out_reg)) |-> $past(sck_fall))
    else $error("single-rate output changed without a falling edge");

  ddr_edge_change_a: assert property (@(posedge clk) disable iff (!resetn)
    $changed(lane_out_reg) |-> ($past(sck_fall) || ($past(ddr_reg) && $past(sck_rise))))
    else $error("output changed without a serial clock edge");

  instr_eight_bits_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == ST_INSTR && state_next != ST_INSTR && !cs_s) |-> (act_rise && cnt_reg == INSTR_LAST))
    else $error("instruction ended before eight bits");

  wp_blocks_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (wr_en || erase_en) |-> (quad_s || lane_s[2]))
    else $error("write or erase under write protect");

  pause_freezes_a: assert property (@(posedge clk) disable iff (!resetn)
    (paused && !cs_s) |=> ($stable(cnt_reg) && $stable(out_cnt_reg) && $stable(addr_reg)))
    else $error("transfer advanced while paused");

  single_lane_out_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == ST_OUT && width_reg == W1) |-> (lane_oe_reg[0] == 1'b0 && lane_oe_reg[3:2] == 2'h0))
    else $error("single read drove a lane other than lane one");

  width_step_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == ST_OUT && act_fall && !ddr_reg) |=> out_cnt_reg == 3'($past(out_cnt_reg) + $past(width_reg)))
    else $error("output bit count did not advance by lane width");

endmodule // mlsi_flash_pins

// ==== tb/mlsi_host_model.sv ====
// Host serial controller model: drives clock, select and lanes, resolves the shared lanes
`timescale 1ns/10ps
module mlsi_host_model (
  input wire logic clk,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe,
  output logic sck,
  output logic cs_n,
  output logic [3:0] lanes
);
  logic [3:0] drv_out;
  logic [3:0] drv_oe;
  logic [1:0] flip;
  logic wp_low;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv_out = 4'h0;
    drv_oe = 4'h0;
    flip = 2'h0;
    wp_low = 1'b0;
  end

  // Lanes 0 and 1 have no pull, so an undriven lane wanders instead of keeping its last value
  always @(posedge clk) begin
    flip <= ~flip;
  end

  // Lanes 2 and 3 are pulled up when nobody drives them; write protect is a host drive of lane 2 low
  assign lanes = (dev_oe & dev_out) | (~dev_oe & drv_oe & drv_out) | (~dev_oe & ~drv_oe & {2'h3, flip});

  // Data moves 2 clk after the previous edge and the edge follows 2 clk later, so setup and hold are both 50 ns
  task automatic half(input logic lvl, input logic [3:0] o, input logic [3:0] oe, output logic [3:0] seen);
    repeat (2) @(posedge clk);
    drv_out <= o & ~{1'b0, wp_low, 2'h0};
    drv_oe <= oe | {1'b0, wp_low, 2'h0};
    repeat (2) @(posedge clk);
    seen = lanes;
    sck <= lvl;
  endtask

  task automatic sdr(input logic [3:0] o, input logic [3:0] oe, output logic [3:0] seen);
    logic [3:0] dummy;
    half(1'b1, o, oe, seen);
    half(1'b0, o, oe, dummy);
  endtask

  task automatic begin_cmd(input logic [7:0] op, input logic [23:0] addr, input bit ddr);
    logic [3:0] s;
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      sdr({3'h0, op[i]}, 4'h1, s);
    end
    for (int i = 23; i >= 0; i--) begin
      if (ddr) begin
        half(i[0], {3'h0, addr[i]}, 4'h1, s);
      end else begin
        sdr({3'h0, addr[i]}, 4'h1, s);
      end
    end
  endtask

  task automatic end_cmd();
    repeat (2) @(posedge clk);
    drv_oe <= 4'h0;
    sck <= 1'b0;
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule // mlsi_host_model

// ==== tb/mlsi_flash_pins_test.sv ====
// Self-checking bench for the multi-lane serial flash pin block
`timescale 1ns/10ps
module mlsi_flash_pins_test import mlsi_pkg::*; ;
  localparam int DEPTH = 64;
  logic clk, resetn, quad_mode_en, sck, cs_n;
  logic [3:0] lanes, dev_out, dev_oe;
  logic [7:0] mem [DEPTH];
  logic [23:0] a;
  logic [3:0] s;
  int mismatches, tests_run, cycles;
  int seed = 90;

  always #12.5 clk = ~clk;

  mlsi_flash_pins #(.MEM_DEPTH(DEPTH), .UNIFORM_SECTORS(1'b0)) i_dut (.clk(clk), .resetn(resetn), .sck(sck),
    .cs_n(cs_n), .quad_mode_en(quad_mode_en),
    .lane0_serial_in_in(lanes[0]), .lane0_serial_in_out(dev_out[0]), .lane0_serial_in_oe(dev_oe[0]),
    .lane1_serial_out_in(lanes[1]), .lane1_serial_out_out(dev_out[1]), .lane1_serial_out_oe(dev_oe[1]),
    .lane2_write_protect_n_in(lanes[2]), .lane2_write_protect_n_out(dev_out[2]),
    .lane2_write_protect_n_oe(dev_oe[2]),
    .lane3_pause_n_in(lanes[3]), .lane3_pause_n_out(dev_out[3]), .lane3_pause_n_oe(dev_oe[3]));

  mlsi_host_model i_host (.clk(clk), .dev_out(dev_out), .dev_oe(dev_oe), .sck(sck), .cs_n(cs_n), .lanes(lanes));

  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reads n bytes at width w; a refused command must leave every lane released
  task automatic rd(input logic [7:0] op, input logic [23:0] addr, input int w, input bit ddr, input int n,
                    input bit ok);
    logic [7:0] b;
    i_host.begin_cmd(op, addr, ddr);
    if (ddr) begin
      i_host.half(1'b1, 4'h0, 4'h0, s);
    end
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8 / w; j++) begin
        // A paused serial clock cycle in mid-byte must neither shift nor skip a bit
        if (!ddr && w < 4 && k == 0 && j == 3) begin
          i_host.sdr(4'h0, 4'h8, s);
        end
        if (ddr) begin
          i_host.half(j[0], 4'h0, 4'h0, s);
        end else begin
          i_host.sdr(4'h0, 4'h0, s);
        end
        b = (w == 1) ? {b[6:0], s[1]} : (w == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
        if (!ok) begin
          check(dev_oe, 4'h0);
        end
      end
      if (ok) begin
        check(b, mem[(addr + k) % DEPTH]);
      end
    end
    i_host.end_cmd();
    check(dev_oe, 4'h0);
  endtask

  task automatic pr(input logic [7:0] op, input logic [23:0] addr, input int n, input bit wp);
    logic [7:0] d;
    i_host.wp_low = wp;
    i_host.begin_cmd(op, addr, 1'b0);
    for (int k = 0; k < n; k++) begin
      d = $random(seed);
      if (op == OP_QPROG) begin
        i_host.sdr(d[7:4], 4'hf, s);
        i_host.sdr(d[3:0], 4'hf, s);
      end else begin
        for (int j = 7; j >= 0; j--) begin
          i_host.sdr({3'h0, d[j]}, 4'h1, s);
        end
      end
      if (!wp) begin
        mem[(addr + k) % DEPTH] = d;
      end
    end
    i_host.end_cmd();
    i_host.wp_low = 1'b0;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    quad_mode_en = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (8) @(posedge clk);
    check({dev_oe, dev_out}, 8'h00);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int t = 0; t < 3; t++) begin
      a = $random(seed);
      pr(OP_PROG, a, 3, 1'b0);
      rd(OP_READ, a, 1, 1'b0, 3, 1'b1);
      // Rewriting a byte in place needs no erase first
      pr(OP_PROG, a + 24'h1, 1, 1'b0);
      rd(OP_READ, a, 1, 1'b0, 3, 1'b1);
    end
    rd(OP_DREAD, a, 2, 1'b0, 4, 1'b1);
    rd(OP_QREAD, a, 4, 1'b0, 2, 1'b0);
    rd(8'h5a, a, 1, 1'b0, 1, 1'b0);
    quad_mode_en <= 1'b1;
    a = $random(seed);
    pr(OP_QPROG, a, 3, 1'b0);
    rd(OP_QREAD, a, 4, 1'b0, 3, 1'b1);
    quad_mode_en <= 1'b0;
    pr(OP_PROG, a, 2, 1'b1);
    rd(OP_READ, a, 1, 1'b0, 2, 1'b1);
    rd(OP_DDR_READ, a, 1, 1'b1, 3, 1'b1);
    i_host.begin_cmd(OP_ERASE, 24'h000123, 1'b0);
    i_host.end_cmd();
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    rd(OP_READ, 24'h000000, 1, 1'b0, DEPTH, 1'b1);
    // Reset in mid-read must release the lanes and leave the device ready for a command
    pr(OP_PROG, 24'h000004, 1, 1'b0);
    i_host.begin_cmd(OP_READ, 24'h000004, 1'b0);
    i_host.sdr(4'h0, 4'h0, s);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check({dev_oe, dev_out}, 8'h00);
    resetn <= 1'b1;
    i_host.end_cmd();
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    rd(OP_READ, 24'h000004, 1, 1'b0, 2, 1'b1);
    wrap_up();
  end
endmodule // mlsi_flash_pins_test
